/* File: core/rscd_consts.svh */
// Purpose: Constants for the reset strap configuration decoder
// Assumes: 16-bit strap word on the upper memory data lines
// Notes:   Bit positions, codes and timing figures as macros
`ifndef RSCD_CONSTS_SVH
`define RSCD_CONSTS_SVH
`define RSCD_WORD_W        16
`define RSCD_WORD_RST      16'hFFFF
`define RSCD_BIT_SRC_SEL   15
`define RSCD_BIT_BUS2      14
`define RSCD_BIT_ASYM      13
`define RSCD_BIT_MULTI_WE  12
`define RSCD_BIT_STD_RAS   11
`define RSCD_BIT_MCLK1     10
`define RSCD_BIT_MCLK0     9
`define RSCD_BIT_ROM32K    8
`define RSCD_BIT_BUS1      7
`define RSCD_BIT_ROM8      6
`define RSCD_BIT_BUS0      5
`define RSCD_BIT_MCLK_INT  4
`define RSCD_BIT_SLEEP     3
`define RSCD_BIT_DAC_ALT   2
`define RSCD_BIT_ZWAIT_OFF 1
`define RSCD_BIT_DAC_ON    0
`define RSCD_RAS_HI_EXT    4'h6
`define RSCD_RAS_LO_EXT    4'h8
`define RSCD_RAS_HI_STD    4'h5
`define RSCD_RAS_LO_STD    4'h7
`define RSCD_MCLK_50       20'h0_C3C2
`define RSCD_MCLK_44       20'h0_AEC8
`define RSCD_MCLK_41       20'h0_A0CD
`define RSCD_MCLK_37       20'h0_92D1
`define RSCD_ROM_BASE      20'hC_0000
`define RSCD_ROM_END64     20'hC_FFFF
`define RSCD_ROM_END32     20'hC_7FFF
`define RSCD_MEM_C000      20'hC_0000
`define RSCD_VGA_EN_A      16'h46E8
`define RSCD_VGA_EN_B      16'h46E9
`define RSCD_VGA_EN_CH     16'h03C3
`define RSCD_DAC_LO        16'h03C6
`define RSCD_DAC_HI        16'h03C9
`define RSCD_DAC_RD_OK     16'h03C7
`define RSCD_DAC_ALT_LO    16'h02EA
`define RSCD_DAC_ALT_HI    16'h02ED
`define RSCD_CMP_A_LO      16'h0290
`define RSCD_CMP_A_HI      16'h029B
`define RSCD_CMP_B_LO      16'h27C0
`define RSCD_CMP_B_HI      16'h27CB
`define RSCD_GATE_46E8_BIT 4
`define RSCD_GATE_REG_BIT  5
`endif

/* File: core/rscd_pkg.sv */
// Purpose: Types for the reset strap configuration decoder
// Assumes: Included constants header
// Notes:   Variant and bus enumerations
package rscd_pkg;
  typedef enum logic [1:0] {RSCD_VAR_SMALL, RSCD_VAR_MID, RSCD_VAR_MID2, RSCD_VAR_LARGE}
    rscd_variant_t;
  typedef enum logic [2:0] {
    RSCD_BUS_RSVD, RSCD_BUS_LB386DX, RSCD_BUS_LB386SX, RSCD_BUS_LB486,
    RSCD_BUS_VLB_FAST, RSCD_BUS_VLB, RSCD_BUS_CHAN, RSCD_BUS_ISA
  } rscd_bus_t;
  typedef enum logic {RSCD_ST_CAPTURE, RSCD_ST_HOLD} rscd_state_t;
endpackage : rscd_pkg

/* File: core/rscd_addr_decode.sv */
// Purpose: Per-access decode of ROM, DAC, enable port and companion ranges
// Assumes: Static settings from the strap capture; same clock domain
// Notes:   Registered outputs, one cycle after the access strobe
`timescale 1ns/1ps
`include "rscd_consts.svh"
module rscd_addr_decode
  import rscd_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_mem_rd,
  input  wire logic        i_mem_acc,
  input  wire logic [19:0] i_mem_addr,
  input  wire logic        i_io_rd,
  input  wire logic        i_io_wr,
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_rom32k,
  input  wire logic        i_rom8,
  input  wire logic        i_zwait_off,
  input  wire logic        i_dac_on,
  input  wire logic        i_dac_alt,
  input  wire logic        i_cmp_en,
  input  wire logic        i_cmp_hi,
  input  wire logic [15:0] i_vga_en_port,
  output logic             o_wide_memory_select,
  output logic             o_zero_wait_out,
  output logic             o_ext_rom_enable_out,
  output logic             o_dac_io_hit,
  output logic             o_dac_shadow_wr,
  output logic             o_vga_en_hit,
  output logic             o_local_device_select
);
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  logic rom_hit, dac_std, dac_any, io_acc;
  logic [6:0] dec_d, dec_q;

  always_comb
  begin
    io_acc  = i_io_rd | i_io_wr;
    rom_hit = i_mem_acc && (i_mem_addr >= `RSCD_ROM_BASE) &&
              (i_mem_addr <= (i_rom32k ? `RSCD_ROM_END32 : `RSCD_ROM_END64));
    dac_std = io_acc && in_rng(i_io_addr, `RSCD_DAC_LO, `RSCD_DAC_HI);
    dac_any = dac_std || (io_acc && !i_dac_alt &&
              in_rng(i_io_addr, `RSCD_DAC_ALT_LO, `RSCD_DAC_ALT_HI));
    dec_d[0] = rom_hit && !i_rom8;
    dec_d[1] = rom_hit && !i_zwait_off;
    // Powered-down DAC hands 3C6-3C9 to the ROM except reads of 3C7
    dec_d[2] = !i_dac_on && ((dac_std && !(i_io_rd && i_io_addr == `RSCD_DAC_RD_OK)) ||
               (i_mem_rd && i_mem_addr[19:4] == `RSCD_MEM_C000 >> 4));
    dec_d[3] = dac_any && (i_dac_on ||
               (i_io_rd && i_io_addr == `RSCD_DAC_RD_OK));
    dec_d[4] = i_io_wr && dac_std;
    dec_d[5] = io_acc && i_io_addr == i_vga_en_port;
    dec_d[6] = io_acc && i_cmp_en && (i_cmp_hi ?
               in_rng(i_io_addr, `RSCD_CMP_B_LO, `RSCD_CMP_B_HI) :
               in_rng(i_io_addr, `RSCD_CMP_A_LO, `RSCD_CMP_A_HI));
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      dec_q <= 7'h00;
    else
      dec_q <= dec_d;
  end

  assign o_wide_memory_select  = dec_q[0];
  assign o_zero_wait_out       = dec_q[1];
  assign o_ext_rom_enable_out  = dec_q[2];
  assign o_dac_io_hit          = dec_q[3];
  assign o_dac_shadow_wr       = dec_q[4];
  assign o_vga_en_hit          = dec_q[5];
  assign o_local_device_select = dec_q[6];
endmodule : rscd_addr_decode

/* File: core/rscd_strap_decoder.sv */
// Purpose: Capture strap word at power-on reset and decode static settings
// Assumes: Strap lines are asynchronous pins; two-flop sync before use
// Notes:   Word is frozen after capture until the next power-on reset
`timescale 1ns/1ps
`include "rscd_consts.svh"
module rscd_strap_decoder
  import rscd_pkg::*;
#(
  parameter rscd_variant_t VARIANT   = RSCD_VAR_MID,
  parameter int            SETTLE_CY = 4
)
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic [15:0] i_memory_data_line,
  input  wire logic        i_mem_rd,
  input  wire logic        i_mem_acc,
  input  wire logic [19:0] i_mem_addr,
  input  wire logic        i_io_rd,
  input  wire logic        i_io_wr,
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_card_setup_select,
  input  wire logic        i_port46e8_bit4,
  input  wire logic        i_reg94_bit5,
  input  wire logic        i_cpu_reset_pin,
  output logic [15:0]      o_strap_config_word,
  output logic             o_config_valid,
  output logic [3:0]       o_switch_readback_register,
  output logic             o_ras_extended,
  output logic [3:0]       o_ras_high_half_mclk,
  output logic [3:0]       o_ras_low_half_mclk,
  output logic [1:0]       o_mclk_sel,
  output logic [19:0]      o_mclk_khz,
  output logic             o_rom_64k,
  output logic [19:0]      o_rom_end_addr,
  output logic             o_rom_16bit,
  output logic             o_mclk_pin_oe,
  output logic             o_mclk_src_mclk_vco,
  output logic [15:0]      o_vga_en_port,
  output logic [2:0]       o_bus_code,
  output logic [2:0]       o_bus_type,
  output logic             o_bus_reserved,
  output logic             o_ready_from_reset_pin,
  output logic             o_local_ready_in,
  output logic             o_cpu_reset_in,
  output logic             o_sleep_46e8,
  output logic             o_option_select_reg_en,
  output logic             o_dram_asym_addr,
  output logic             o_multi_we,
  output logic             o_second_row_strobe_mode,
  output logic             o_dac_powered,
  output logic             o_wide_memory_select,
  output logic             o_zero_wait_out,
  output logic             o_zero_wait_oe,
  output logic             o_ext_rom_enable_out,
  output logic             o_dac_io_hit,
  output logic             o_dac_shadow_wr,
  output logic             o_vga_en_hit,
  output logic             o_local_device_select
);
  localparam logic [3:0] SETTLE_W = 4'(SETTLE_CY);

  function automatic rscd_bus_t bus_decode(input logic [2:0] c, input rscd_variant_t v);
    bus_decode = RSCD_BUS_RSVD;
    if (v == RSCD_VAR_SMALL)
      bus_decode = c[1] ? RSCD_BUS_ISA : RSCD_BUS_CHAN;
    else
      unique case (c)
        3'b001: bus_decode = RSCD_BUS_LB386DX;
        3'b010: bus_decode = RSCD_BUS_LB386SX;
        3'b011: bus_decode = (v == RSCD_VAR_LARGE) ? RSCD_BUS_RSVD : RSCD_BUS_LB486;
        3'b100: bus_decode = (v == RSCD_VAR_LARGE) ? RSCD_BUS_VLB_FAST : RSCD_BUS_RSVD;
        3'b110: bus_decode = RSCD_BUS_VLB;
        3'b101: bus_decode = RSCD_BUS_CHAN;
        3'b111: bus_decode = RSCD_BUS_ISA;
        3'b000: bus_decode = RSCD_BUS_RSVD;
      endcase
  endfunction : bus_decode

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser and capture
  logic [15:0]  sync1_q, sync2_q;
  logic [15:0]  word_d, word_q;
  rscd_state_t  st_d, st_q;
  logic [3:0]   cnt_d, cnt_q;

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync1_q <= `RSCD_WORD_RST;
      sync2_q <= `RSCD_WORD_RST;
    end
    else
    begin
      sync1_q <= i_memory_data_line;
      sync2_q <= sync1_q;
    end
  end

  // Pull-ups read as one, so an unstrapped board captures all ones
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    word_d = word_q;
    unique case (st_q)
      RSCD_ST_CAPTURE:
      begin
        word_d = sync2_q;
        cnt_d  = cnt_q + 4'h1;
        if (cnt_q >= SETTLE_W)
          st_d = RSCD_ST_HOLD;
      end
      RSCD_ST_HOLD:
      begin
        word_d = word_q;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_q   <= RSCD_ST_CAPTURE;
      cnt_q  <= 4'h0;
      word_q <= `RSCD_WORD_RST;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      word_q <= word_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Static decode, plus live option gate, ready and CPU reset
  logic        is_small, is_large, is_chan, is_vlb, sleep46, chan_bit;
  logic [2:0]  code;
  rscd_bus_t   bus;
  logic [51:0] set_d, set_q;
  logic [19:0] khz;

  always_comb
  begin
    is_small = (VARIANT == RSCD_VAR_SMALL);
    is_large = (VARIANT == RSCD_VAR_LARGE);
    code     = {word_q[`RSCD_BIT_BUS2], word_q[`RSCD_BIT_BUS1], word_q[`RSCD_BIT_BUS0]};
    bus      = bus_decode(code, VARIANT);
    is_chan  = (bus == RSCD_BUS_CHAN);
    is_vlb   = (bus == RSCD_BUS_VLB) || (bus == RSCD_BUS_VLB_FAST);
    chan_bit = word_q[`RSCD_BIT_SLEEP];
    sleep46  = is_chan ? !chan_bit : chan_bit;
    unique case ({word_q[`RSCD_BIT_MCLK1], word_q[`RSCD_BIT_MCLK0]})
      2'b00: khz = `RSCD_MCLK_50;
      2'b01: khz = `RSCD_MCLK_44;
      2'b10: khz = `RSCD_MCLK_41;
      2'b11: khz = `RSCD_MCLK_37;
    endcase
    set_d = '0;
    set_d[3:0]   = is_small ? word_q[15:12] : 4'h0;
    set_d[4]     = !word_q[`RSCD_BIT_STD_RAS];
    set_d[8:5]   = word_q[`RSCD_BIT_STD_RAS] ? `RSCD_RAS_HI_STD : `RSCD_RAS_HI_EXT;
    set_d[12:9]  = word_q[`RSCD_BIT_STD_RAS] ? `RSCD_RAS_LO_STD : `RSCD_RAS_LO_EXT;
    set_d[14:13] = {word_q[`RSCD_BIT_MCLK1], word_q[`RSCD_BIT_MCLK0]};
    set_d[15]    = !word_q[`RSCD_BIT_ROM32K];
    set_d[16]    = !word_q[`RSCD_BIT_ROM8];
    set_d[17]    = word_q[`RSCD_BIT_MCLK_INT];
    set_d[18]    = is_large && word_q[`RSCD_BIT_SRC_SEL];
    // Enable port relocation only exists on the small part with an AT host
    if (is_small && is_chan)
      set_d[34:19] = `RSCD_VGA_EN_CH;
    else if (is_small)
      set_d[34:19] = chan_bit ? `RSCD_VGA_EN_A : `RSCD_VGA_EN_B;
    else
      set_d[34:19] = sleep46 ? `RSCD_VGA_EN_A : `RSCD_VGA_EN_CH;
    set_d[37:35] = code;
    set_d[40:38] = bus;
    set_d[41]    = (bus == RSCD_BUS_RSVD);
    set_d[42]    = is_vlb;
    set_d[43]    = sleep46;
    set_d[44]    = !is_small && word_q[`RSCD_BIT_ASYM];
    set_d[45]    = !is_small && word_q[`RSCD_BIT_MULTI_WE];
    set_d[46]    = (VARIANT == RSCD_VAR_MID2 || is_large) &&
                   !word_q[`RSCD_BIT_ASYM] && !word_q[`RSCD_BIT_MULTI_WE];
    set_d[47]    = is_small || word_q[`RSCD_BIT_DAC_ON];
    // Option register gate follows live host signals, so it is not static
    if (is_chan)
      set_d[48] = i_card_setup_select;
    else
      set_d[48] = sleep46 ? i_port46e8_bit4 : i_reg94_bit5;
    set_d[49]    = is_vlb ? i_cpu_reset_pin : 1'b1;
    set_d[50]    = is_vlb ? 1'b0 : i_cpu_reset_pin;
    set_d[51]    = (st_q == RSCD_ST_HOLD);
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      set_q <= 52'h0_0000_0000_0000;
    else
      set_q <= set_d;
  end

  logic [19:0] khz_q, rom_end_q;
  logic [15:0] word_out_q;
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      khz_q      <= 20'h0_0000;
      rom_end_q  <= 20'h0_0000;
      word_out_q <= `RSCD_WORD_RST;
    end
    else
    begin
      khz_q      <= khz;
      rom_end_q  <= word_q[`RSCD_BIT_ROM32K] ? `RSCD_ROM_END32 : `RSCD_ROM_END64;
      word_out_q <= word_q;
    end
  end

  assign o_strap_config_word        = word_out_q;
  assign o_config_valid             = set_q[51];
  assign o_switch_readback_register = set_q[3:0];
  assign o_ras_extended             = set_q[4];
  assign o_ras_high_half_mclk       = set_q[8:5];
  assign o_ras_low_half_mclk        = set_q[12:9];
  assign o_mclk_sel                 = set_q[14:13];
  assign o_mclk_khz                 = khz_q;
  assign o_rom_64k                  = set_q[15];
  assign o_rom_end_addr             = rom_end_q;
  assign o_rom_16bit                = set_q[16];
  assign o_mclk_pin_oe              = set_q[17];
  assign o_mclk_src_mclk_vco        = set_q[18];
  assign o_vga_en_port              = set_q[34:19];
  assign o_bus_code                 = set_q[37:35];
  assign o_bus_type                 = set_q[40:38];
  assign o_bus_reserved             = set_q[41];
  assign o_ready_from_reset_pin     = set_q[42];
  assign o_local_ready_in           = set_q[49];
  assign o_cpu_reset_in             = set_q[50];
  assign o_sleep_46e8               = set_q[43];
  assign o_option_select_reg_en     = set_q[48];
  assign o_dram_asym_addr           = set_q[44];
  assign o_multi_we                 = set_q[45];
  assign o_second_row_strobe_mode   = set_q[46];
  assign o_dac_powered              = set_q[47];
  assign o_zero_wait_oe             = o_zero_wait_out;

  ////////////////////////////////////////////////////////////////////////////
  // Access-time decode, fed from the frozen settings
  rscd_addr_decode u_dec (
    .i_sys_clk             (i_sys_clk),
    .i_rstn                (i_rstn),
    .i_mem_rd              (i_mem_rd),
    .i_mem_acc             (i_mem_acc),
    .i_mem_addr            (i_mem_addr),
    .i_io_rd               (i_io_rd),
    .i_io_wr               (i_io_wr),
    .i_io_addr             (i_io_addr),
    .i_rom32k              (!set_q[15]),
    .i_rom8                (!set_q[16]),
    .i_zwait_off           (word_q[`RSCD_BIT_ZWAIT_OFF] || !set_q[51]),
    .i_dac_on              (set_q[47]),
    .i_dac_alt             (is_small || word_q[`RSCD_BIT_DAC_ALT] || is_large),
    .i_cmp_en              (is_large && !word_q[`RSCD_BIT_ZWAIT_OFF]),
    .i_cmp_hi              (word_q[`RSCD_BIT_DAC_ALT]),
    .i_vga_en_port         (set_q[34:19]),
    .o_wide_memory_select  (o_wide_memory_select),
    .o_zero_wait_out       (o_zero_wait_out),
    .o_ext_rom_enable_out  (o_ext_rom_enable_out),
    .o_dac_io_hit          (o_dac_io_hit),
    .o_dac_shadow_wr       (o_dac_shadow_wr),
    .o_vga_en_hit          (o_vga_en_hit),
    .o_local_device_select (o_local_device_select)
  );
endmodule : rscd_strap_decoder

/* File: bench/rscd_strap_board.sv */
// Purpose: Board strap resistors and memory traffic on the upper data lines
// Assumes: Unfitted lines float high through the on-chip pull-ups
// Notes:   Traffic pattern changes every cycle once the word is captured
`timescale 1ns/1ps
module rscd_strap_board
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_bus_busy,
  input  wire logic [15:0] i_pull_dn,
  output logic      [15:0] o_memory_data_line
);
  logic [15:0] traffic_q;
  initial traffic_q = 16'h1D2B;
  // Busy data must never look like the strap word, so it keeps moving
  always @(posedge i_sys_clk) traffic_q <= traffic_q * 16'h0005 + 16'h3A71;
  // Fitted resistor pulls its line low, others pulled high
  assign o_memory_data_line = i_bus_busy ? traffic_q : ~i_pull_dn;
endmodule : rscd_strap_board

/* File: bench/rscd_strap_sva.sv */
// Purpose: Port assertions for the strap decoder
// Assumes: One clock domain, async active-low reset
// Notes:   Static checks start one cycle after o_config_valid
`timescale 1ns/1ps
`include "rscd_consts.svh"
module rscd_strap_sva
  import rscd_pkg::*;
#(
  parameter rscd_variant_t VARIANT = RSCD_VAR_MID
)
(
  input wire logic        i_sys_clk,
  input wire logic        i_rstn,
  input wire logic        i_mem_acc,
  input wire logic [19:0] i_mem_addr,
  input wire logic        i_io_wr,
  input wire logic [15:0] i_io_addr,
  input wire logic [15:0] o_strap_config_word,
  input wire logic        o_config_valid,
  input wire logic        o_ras_extended,
  input wire logic [3:0]  o_ras_high_half_mclk,
  input wire logic [1:0]  o_mclk_sel,
  input wire logic [19:0] o_mclk_khz,
  input wire logic [19:0] o_rom_end_addr,
  input wire logic        o_mclk_pin_oe,
  input wire logic [2:0]  o_bus_code,
  input wire logic        o_bus_reserved,
  input wire logic        o_second_row_strobe_mode,
  input wire logic        o_wide_memory_select,
  input wire logic        o_zero_wait_out,
  input wire logic        o_ext_rom_enable_out
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic [15:0] w;
  logic        rom_hit;
  logic        settled_q;
  assign w = o_strap_config_word;
  assign rom_hit = i_mem_acc && i_mem_addr >= `RSCD_ROM_BASE
                   && i_mem_addr <= (w[8] ? `RSCD_ROM_END32 : `RSCD_ROM_END64);
  // Static outputs lag the frozen word by one edge
  always_ff @(posedge i_sys_clk or negedge i_rstn)
    if (!i_rstn) settled_q <= 1'b0;
    else settled_q <= o_config_valid;
  ////////////////////////////////////////////////////////////////////////////
  property p_frozen;
    settled_q |-> $stable(w);
  endproperty
  a_frozen: assert property (p_frozen) else $error("strap word moved");
  property p_ras_time;
    settled_q |-> o_ras_extended == !w[11]
      && o_ras_high_half_mclk == (w[11] ? `RSCD_RAS_HI_STD : `RSCD_RAS_HI_EXT);
  endproperty
  a_ras_time: assert property (p_ras_time) else $error("ras timing wrong");
  property p_mclk;
    settled_q |-> o_mclk_sel == w[10:9] && o_mclk_khz == (w[10]
      ? (w[9] ? `RSCD_MCLK_37 : `RSCD_MCLK_41) : (w[9] ? `RSCD_MCLK_44 : `RSCD_MCLK_50));
  endproperty
  a_mclk: assert property (p_mclk) else $error("mclk default wrong");
  property p_rom_size;
    settled_q |-> o_rom_end_addr == (w[8] ? `RSCD_ROM_END32 : `RSCD_ROM_END64);
  endproperty
  a_rom_size: assert property (p_rom_size) else $error("rom window wrong");
  property p_wide;
    settled_q && rom_hit |=> o_wide_memory_select == !w[6];
  endproperty
  a_wide: assert property (p_wide) else $error("wide select wrong");
  property p_mclk_oe;
    settled_q |-> o_mclk_pin_oe == w[4];
  endproperty
  a_mclk_oe: assert property (p_mclk_oe) else $error("mclk pin dir wrong");
  property p_zero_wait;
    settled_q && rom_hit |=> o_zero_wait_out == !w[1];
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("zero wait wrong");
  property p_second_ras;
    settled_q |-> o_second_row_strobe_mode
      == (VARIANT inside {RSCD_VAR_MID2, RSCD_VAR_LARGE} && w[13:12] == 2'b00);
  endproperty
  a_second_ras: assert property (p_second_ras) else $error("second strobe wrong");
  property p_bus;
    settled_q && VARIANT inside {RSCD_VAR_MID, RSCD_VAR_MID2}
      |-> o_bus_code == {w[14], w[7], w[5]} && o_bus_reserved == (!w[7] && !w[5]);
  endproperty
  a_bus: assert property (p_bus) else $error("bus code wrong");
  property p_ext_rom;
    settled_q && VARIANT != RSCD_VAR_SMALL && !w[0] && i_io_wr
      && i_io_addr >= `RSCD_DAC_LO && i_io_addr <= `RSCD_DAC_HI |=> o_ext_rom_enable_out;
  endproperty
  a_ext_rom: assert property (p_ext_rom) else $error("rom enable missing");
endmodule : rscd_strap_sva

/* File: bench/test_reset_strap_config_decoder.sv */
// Purpose: Self-checking bench for the strap decoder
// Assumes: Inputs change on the falling edge, decodes answer one cycle later
// Notes:   Each strap set gets its own power-on reset
`timescale 1ns/1ps
`include "rscd_consts.svh"
module test_reset_strap_config_decoder;
  import rscd_pkg::*;
  localparam rscd_variant_t VARIANT = RSCD_VAR_MID2;
  localparam rscd_bus_t BUS_TAB [8] = '{RSCD_BUS_RSVD, RSCD_BUS_LB386DX, RSCD_BUS_LB386SX,
    RSCD_BUS_LB486, RSCD_BUS_RSVD, RSCD_BUS_CHAN, RSCD_BUS_VLB, RSCD_BUS_ISA};
  localparam logic [19:0] MEM_PICK [8] = '{20'hC_0000, 20'hC_000F, 20'hC_0010, 20'hC_7FFF,
    20'hC_8000, 20'hC_FFFF, 20'hD_0000, 20'hB_FFFF};
  localparam logic [15:0] IA [8] = '{16'h03C6, 16'h03C7, 16'h03C9, 16'h03CA,
    16'h02EA, 16'h02ED, 16'h02EE, 16'h03C3};
  logic        i_sys_clk, i_rstn, i_mem_rd, i_mem_acc, i_io_rd, i_io_wr, i_cpu_reset_pin;
  logic        i_card_setup_select, i_port46e8_bit4, i_reg94_bit5, bus_busy;
  logic [19:0] i_mem_addr, o_mclk_khz, o_rom_end_addr;
  logic [15:0] i_io_addr, pull_dn, i_memory_data_line, o_strap_config_word, w;
  logic [3:0]  o_ras_high_half_mclk, o_ras_low_half_mclk;
  logic [2:0]  o_bus_type;
  logic        o_config_valid, o_local_ready_in, o_sleep_46e8, o_option_select_reg_en;
  logic        o_multi_we, o_second_row_strobe_mode, o_wide_memory_select, o_zero_wait_out;
  logic        o_ext_rom_enable_out, o_dac_io_hit, o_dac_shadow_wr, rom, dac, chan, s46;
  int          err_total, total_checks, cnt, seed_ret;
  logic [3:0]  o_switch_readback_register;
  logic [15:0] o_vga_en_port;
  logic        o_dram_asym_addr, o_dac_powered, o_vga_en_hit, o_cpu_reset_in;
  logic        o_local_device_select, o_zero_wait_oe;

  rscd_strap_board i_board (.i_sys_clk, .i_bus_busy(bus_busy), .i_pull_dn(pull_dn),
    .o_memory_data_line(i_memory_data_line));
  rscd_strap_decoder #(.VARIANT(VARIANT), .SETTLE_CY(4)) i_dut (
    .i_sys_clk, .i_rstn, .i_memory_data_line, .i_mem_rd, .i_mem_acc, .i_mem_addr, .i_io_rd,
    .i_io_wr, .i_io_addr, .i_card_setup_select, .i_port46e8_bit4, .i_reg94_bit5,
    .i_cpu_reset_pin, .o_strap_config_word, .o_config_valid, .o_switch_readback_register,
    .o_ras_extended(), .o_ras_high_half_mclk, .o_ras_low_half_mclk, .o_mclk_sel(),
    .o_mclk_khz, .o_rom_64k(), .o_rom_end_addr, .o_rom_16bit(), .o_mclk_pin_oe(),
    .o_mclk_src_mclk_vco(), .o_vga_en_port, .o_bus_code(), .o_bus_type, .o_bus_reserved(),
    .o_ready_from_reset_pin(), .o_local_ready_in, .o_cpu_reset_in, .o_sleep_46e8,
    .o_option_select_reg_en, .o_dram_asym_addr, .o_multi_we, .o_second_row_strobe_mode,
    .o_dac_powered, .o_wide_memory_select, .o_zero_wait_out, .o_zero_wait_oe,
    .o_ext_rom_enable_out, .o_dac_io_hit, .o_dac_shadow_wr, .o_vga_en_hit,
    .o_local_device_select);

  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // Outputs seen now answer the inputs still on the ports
  task automatic check_access();
    rom = i_mem_acc && i_mem_addr >= `RSCD_ROM_BASE
          && i_mem_addr <= (w[8] ? `RSCD_ROM_END32 : `RSCD_ROM_END64);
    dac = (i_io_rd || i_io_wr) && i_io_addr >= `RSCD_DAC_LO && i_io_addr <= `RSCD_DAC_HI;
    chk("wide", rom && !w[6], o_wide_memory_select);
    chk("zero_wait", rom && !w[1], o_zero_wait_out);
    chk("zero_wait_oe", rom && !w[1], o_zero_wait_oe);
    chk("ext_rom", !w[0] && (dac && !(i_io_rd && i_io_addr == `RSCD_DAC_RD_OK)
      || i_mem_rd && i_mem_addr[19:4] == 16'hC000), o_ext_rom_enable_out);
    if (w[0])
      chk("dac_hit", dac || (i_io_rd || i_io_wr) && !w[2] && i_io_addr >= `RSCD_DAC_ALT_LO
        && i_io_addr <= `RSCD_DAC_ALT_HI, o_dac_io_hit);
    else
      chk("dac_hit", i_io_rd && i_io_addr == `RSCD_DAC_RD_OK, o_dac_io_hit);
    if (!w[0] && i_io_wr && dac)
      chk("shadow", 1'b1, o_dac_shadow_wr);
    chk("sleep", s46, o_sleep_46e8);
    chk("opt_gate", chan ? i_card_setup_select : s46 ? i_port46e8_bit4 : i_reg94_bit5,
      o_option_select_reg_en);
    chk("ready", BUS_TAB[{w[14], w[7], w[5]}] == RSCD_BUS_VLB ? i_cpu_reset_pin : 1'b1,
      o_local_ready_in);
    chk("cpu_rst", BUS_TAB[{w[14], w[7], w[5]}] != RSCD_BUS_VLB && i_cpu_reset_pin,
      o_cpu_reset_in);
    chk("vga_hit", (i_io_rd || i_io_wr)
      && i_io_addr == (s46 ? `RSCD_VGA_EN_A : `RSCD_VGA_EN_CH), o_vga_en_hit);
    chk("local_dev", 1'b0, o_local_device_select);
  endtask : check_access

  task automatic drive_access();
    cnt = $urandom_range(0, 2);
    i_mem_rd = ($urandom_range(0, 2) == 0);
    i_mem_acc = i_mem_rd | 1'($urandom_range(0, 1));
    i_mem_addr = MEM_PICK[$urandom_range(0, 7)];
    i_io_rd = (cnt == 1);
    i_io_wr = (cnt == 2);
    i_io_addr = IA[$urandom_range(0, 7)];
    {i_card_setup_select, i_port46e8_bit4, i_reg94_bit5, i_cpu_reset_pin} = 4'($urandom);
  endtask : drive_access
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {i_rstn, i_mem_rd, i_mem_acc, i_io_rd, i_io_wr, i_cpu_reset_pin, bus_busy} = '0;
    {i_card_setup_select, i_port46e8_bit4, i_reg94_bit5} = '0;
    {i_mem_addr, i_io_addr, pull_dn, err_total, total_checks} = '0;
    seed_ret = $urandom(32'hd8443fa2);
    for (int n = 0; n < 14; n++)
    begin
      // First two: no resistors, then every resistor fitted
      pull_dn = (n == 0) ? 16'h0000 : (n == 1) ? 16'hFFFF : 16'($urandom);
      if (n > 1)
        {pull_dn[14], pull_dn[7], pull_dn[5], pull_dn[10:9]} = ~{n[2:0], n[1:0]};
      @(negedge i_sys_clk);
      i_rstn = 1'b0;
      repeat (16) @(negedge i_sys_clk);
      i_rstn = 1'b1;
      cnt = 0;
      while (o_config_valid !== 1'b1 && cnt < 40)
      begin
        @(negedge i_sys_clk);
        cnt++;
      end
      repeat (2) @(negedge i_sys_clk);
      w = ~pull_dn;
      chan = (BUS_TAB[{w[14], w[7], w[5]}] == RSCD_BUS_CHAN);
      s46 = chan ? !w[3] : w[3];
      chk("valid", 1'b1, o_config_valid);
      chk("word", w, o_strap_config_word);
      chk("ras_lo", w[11] ? `RSCD_RAS_LO_STD : `RSCD_RAS_LO_EXT, o_ras_low_half_mclk);
      chk("mclk_khz", w[10] ? (w[9] ? `RSCD_MCLK_37 : `RSCD_MCLK_41)
        : (w[9] ? `RSCD_MCLK_44 : `RSCD_MCLK_50), o_mclk_khz);
      chk("rom_end", w[8] ? `RSCD_ROM_END32 : `RSCD_ROM_END64, o_rom_end_addr);
      chk("multi_we", w[12], o_multi_we);
      chk("row_strobe2", w[13:12] == 2'b00, o_second_row_strobe_mode);
      chk("bus", BUS_TAB[{w[14], w[7], w[5]}], o_bus_type);
      chk("vga_port", s46 ? `RSCD_VGA_EN_A : `RSCD_VGA_EN_CH, o_vga_en_port);
      chk("asym", w[13], o_dram_asym_addr);
      chk("dac_pwr", w[0], o_dac_powered);
      chk("switches", 4'h0, o_switch_readback_register);
      bus_busy = 1'b1;
      drive_access();
      for (int k = 0; k < 80; k++)
      begin
        @(negedge i_sys_clk);
        check_access();
        drive_access();
      end
      chk("word_hold", w, o_strap_config_word);
      {i_mem_rd, i_mem_acc, i_io_rd, i_io_wr, bus_busy} = '0;
    end
    tally_and_finish();
  end

  initial
  begin
    #200000;
    err_total++;
    tally_and_finish();
  end
endmodule : test_reset_strap_config_decoder

bind rscd_strap_decoder rscd_strap_sva #(.VARIANT(VARIANT)) i_sva (
  .i_sys_clk, .i_rstn, .i_mem_acc, .i_mem_addr, .i_io_wr, .i_io_addr,
  .o_strap_config_word, .o_config_valid, .o_ras_extended, .o_ras_high_half_mclk,
  .o_mclk_sel, .o_mclk_khz, .o_rom_end_addr, .o_mclk_pin_oe, .o_bus_code, .o_bus_reserved,
  .o_second_row_strobe_mode, .o_wide_memory_select, .o_zero_wait_out, .o_ext_rom_enable_out);
